// [testbench/tb_top.sv]
// Self-checking bench for the trigger-function panel.
// Assumes zero-wait APB and one-cycle trigger latency.
`timescale 1ns/1ns
module tb_top
   import trigger_programming_panel_pkg::*;
;
   logic              pclk = 1'h0;
   logic              presetn = 1'h0;
   logic              psel = 1'h0;
   logic              penable = 1'h0;
   logic              pwrite = 1'h0;
   logic [7:0]        paddr = 8'h0;
   logic [31:0]       pwdata = 32'h0;
   logic [31:0]       prdata;
   logic [31:0]       rd;
   logic              pready, pslverr, er, trigger_programming_out, mon, mode_led;
   logic [3:0]        lv = 4'h0;
   logic [3:0]        red, green, flash, disp;
   logic [15:0]       step, sweeps, c0;
   int                err_count = 0;
   int                cmp_count = 0;
   int                cycles = 0;
   // Row: command, levels, trigger, red, green, mode light
   logic [21:0]       rows [14] = '{
      {8'h00, 4'h1, 1'h0, 4'h0, 4'h0, 1'h0},
      {8'h01, 4'h1, 1'h0, 4'h0, 4'h0, 1'h1},
      {8'h06, 4'h1, 1'h1, 4'h1, 4'h0, 1'h1},
      {8'h00, 4'h2, 1'h0, 4'h1, 4'h0, 1'h1},
      {8'h03, 4'h0, 1'h1, 4'h0, 4'h1, 1'h1},
      {8'h03, 4'h1, 1'h1, 4'h1, 4'h0, 1'h1},
      {8'h05, 4'h1, 1'h1, 4'h1, 4'h0, 1'h1},
      {8'h16, 4'h1, 1'h0, 4'h3, 4'h0, 1'h1},
      {8'h00, 4'h3, 1'h1, 4'h3, 4'h0, 1'h1},
      {8'h02, 4'h3, 1'h0, 4'h0, 4'h0, 1'h1},
      {8'h06, 4'h1, 1'h1, 4'h1, 4'h0, 1'h1},
      {8'h01, 4'h1, 1'h1, 4'h1, 4'h0, 1'h0},
      {8'h07, 4'h1, 1'h1, 4'h1, 4'h0, 1'h0},
      {8'h00, 4'h0, 1'h0, 4'h1, 4'h0, 1'h0}};

   trigger_programming_panel uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_one(lv[0]), .input_two(lv[1]), .input_three(lv[2]), .input_four(lv[3]),
      .trigger_programming_out(trigger_programming_out), .trigger_monitor_trace(mon), .program_mode_select_led(mode_led),
      .term_led_red(red), .term_led_green(green), .term_led_flash(flash), .disp_on(disp),
      .vdiv_step(step));
   time_base_model tbm (.pclk(pclk), .presetn(presetn), .trigger_programming_in(trigger_programming_out), .sweeps(sweeps));

   always #5 pclk = ~pclk;

   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Request held until pready is seen high; data taken at that edge only
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task press(input logic [7:0] c);
      apb(1'h1, A_CMD, {24'h0, c});
   endtask : press

   // Same command twice back to back: psel stays up, the next setup follows at once
   task press2(input logic [7:0] c);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= 1'h1;
      paddr <= A_CMD;
      pwdata <= {24'h0, c};
      repeat (2) begin
         @(posedge pclk);
         penable <= 1'h1;
         do begin
            @(posedge pclk);
         end while (pready !== 1'h1);
         penable <= 1'h0;
      end
      psel <= 1'h0;
   endtask : press2

   // Sample on the falling edge so register updates have landed
   task settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : settle

   // Hang guard: far above the few hundred cycles the run needs
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         $display("timeout");
         wrap_up;
      end
   end

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      int i;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, A_STAT, 32'h0);
      chk("stat", 32'h0001_0000, rd);
      apb(1'h0, A_STEP, 32'h0);
      chk("step", 32'h0000_3333, rd);
      apb(1'h0, A_CTRL, 32'h0);
      chk("ctrl", 32'h1, rd);
      apb(1'h0, A_CMD, 32'h0);
      chk("cmd", 32'h0, rd);
      apb(1'h0, 8'h10, 32'h0);
      chk("unmapped err", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rd);
      $display("test reset done");
      for (i = 0; i < 14; i++) begin
         @(posedge pclk);
         lv <= rows[i][13:10];
         if (rows[i][21:14] != 8'h0) begin
            press(rows[i][21:14]);
         end
         settle(3);
         chk("trigger_programming", 32'(rows[i][9]), 32'(trigger_programming_out));
         chk("monitor", 32'(rows[i][9]), 32'(mon));
         chk("red", 32'(rows[i][8:5]), 32'(red));
         chk("green", 32'(rows[i][4:1]), 32'(green));
         chk("mode", 32'(rows[i][0]), 32'(mode_led));
      end
      $display("test table done");
      chk("disp", 32'h0, 32'(disp));
      press(8'h16);
      press(8'h07);
      settle(2);
      chk("disp", 32'h2, 32'(disp));
      press(8'h08);
      settle(2);
      chk("vdiv", 32'h3343, 32'(step));
      apb(1'h1, A_CTRL, 32'h0);
      lv <= 4'h1;
      settle(3);
      chk("trigger_programming", 32'h1, 32'(trigger_programming_out));
      chk("monitor", 32'h0, 32'(mon));
      apb(1'h1, A_CTRL, 32'h1);
      $display("test channel mode done");
      press(8'h01);
      press(8'h06);
      press(8'h04);
      settle(3);
      chk("flash", 32'h1, 32'(flash));
      chk("trigger_programming", 32'h0, 32'(trigger_programming_out));
      c0 = sweeps;
      @(posedge pclk);
      lv <= 4'h0;
      settle(2);
      @(posedge pclk);
      lv <= 4'h1;
      settle(4);
      chk("sweeps", 32'(c0 + 16'h1), 32'(sweeps));
      press(8'h04);
      settle(3);
      chk("flash", 32'h0, 32'(flash));
      chk("trigger_programming", 32'h1, 32'(trigger_programming_out));
      $display("test edge done");
      // Two inverts on the live term cancel; after clear, modifiers with no live term wait for the next channel press
      press2(8'h03);
      settle(2);
      chk("red", 32'h1, 32'(red));
      chk("green", 32'h0, 32'(green));
      press(8'h02);
      press(8'h03);
      press(8'h04);
      press(8'h06);
      settle(3);
      chk("green", 32'h1, 32'(green));
      chk("flash", 32'h1, 32'(flash));
      chk("trigger_programming", 32'h0, 32'(trigger_programming_out));
      press(8'h01);
      press(8'h09);
      settle(2);
      chk("vdiv", 32'h3342, 32'(step));
      $display("test pending and pair done");
      @(posedge pclk);
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, A_STAT, 32'h0);
      chk("stat", 32'h0001_0000, rd);
      chk("vdiv", 32'h3333, 32'(step));
      chk("trigger_programming", 32'h0, 32'(trigger_programming_out));
      $display("test mid reset done");
      wrap_up;
   end
endmodule : tb_top

// [testbench/time_base_model.sv]
// Time-base stand-in: each rise of the trigger level starts one sweep.
// Assumes the trigger is a level synchronous to pclk.
`timescale 1ns/1ns
module time_base_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        trigger_programming_in,
   output logic [15:0]      sweeps
);
   logic trigger_programming_q;

   // A held level starts no new sweep, so only fresh rises are counted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_programming_q <= 1'h0;
         sweeps <= 16'h0;
      end else begin
         trigger_programming_q <= trigger_programming_in;
         if (trigger_programming_in && !trigger_programming_q) begin
            sweeps <= sweeps + 16'h1;
         end
      end
   end
endmodule : time_base_model

// [verilog/apb_panel_if.sv]
// APB slave decode for the panel registers: strobes and read mux.
// Zero wait states; unmapped addresses answer with pslverr and zero data.
`timescale 1ns/1ns
module apb_panel_if
   import trigger_programming_panel_pkg::*;
(
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       ctrl_rd,
   input  wire logic [31:0]       stat_rd,
   input  wire logic [31:0]       step_rd,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   wr_cmd,
   output logic                   wr_ctrl
);
   logic access;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a == A_CMD) || (a == A_CTRL) || (a == A_STAT) || (a == A_STEP);
   endfunction : mapped

   // Access phase; every transfer completes in its first access cycle
   assign access  = psel & penable;
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped(paddr);
   assign wr_cmd  = access & pwrite & (paddr == A_CMD);
   assign wr_ctrl = access & pwrite & (paddr == A_CTRL);

   // Read mux; command register reads as zero
   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         unique case (paddr)
            A_CTRL:  prdata = ctrl_rd;
            A_STAT:  prdata = stat_rd;
            A_STEP:  prdata = step_rd;
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

endmodule : apb_panel_if

// [verilog/term_eval.sv]
// One channel term of the trigger function: polarity and edge qualification.
// Assumes the level input is already threshold-compared and synchronous.
`timescale 1ns/1ns
module term_eval
   import trigger_programming_panel_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level,
   input  wire logic en,
   input  wire logic inv,
   input  wire logic edge_q,
   output logic      match
);
   logic act;
   logic prev_q;

   // Polarity: an inverted term is true on the low level
   assign act = level ^ inv;

   // Previous active value, kept every cycle so an edge is seen at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= act;
      end
   end

   // Unprogrammed term is neutral in the product (true)
   always_comb begin
      if (!en) begin
         match = 1'b1;
      end else if (edge_q) begin
         match = act & ~prev_q;
      end else begin
         match = act;
      end
   end

endmodule : term_eval

// [verilog/trigger_programming_panel.sv]
// Trigger-function panel: button commands over APB build a product of channel
// terms that drives the time-base trigger and the monitor trace.
// Assumes channel levels are threshold-compared and synchronous to pclk.
`timescale 1ns/1ns

// Operation
// [R1] Second edge press restores level, stops flashing
// [R2] AND then channel: both terms must hold
// [R3] Unsatisfied function gives no trigger at all
// [R4] Clear removes all terms, all indicators off
// [R5] Program button toggles channel/trigger mode
// [R6] Trigger mode channel press adds active-high red term
// [R7] Invert makes term active-low, indicator green
// [R8] Second invert restores active-high, indicator red
// [R9] Display off keeps channel in trigger evaluation
// [R10] Channel mode: display toggles trace, light, readout
// [R11] Upper deflection press steps one more sensitive
// [R12] Monitor trace shows function output only
// [R13] Unprogrammed channel never influences trigger
// [R14] Function evaluated every cycle from held terms
module trigger_programming_panel
   import trigger_programming_panel_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              input_one,
   input  wire logic              input_two,
   input  wire logic              input_three,
   input  wire logic              input_four,
   output logic                   trigger_programming_out,
   output logic                   trigger_monitor_trace,
   output logic                   program_mode_select_led,
   output logic [NCH-1:0]         term_led_red,
   output logic [NCH-1:0]         term_led_green,
   output logic [NCH-1:0]         term_led_flash,
   output logic [NCH-1:0]         disp_on,
   output logic [NCH*STEP_W-1:0]  vdiv_step
);
   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   program_mode_select_mode_t          mode_q;
   logic [CH_W-1:0]     sel_q;
   logic                and_pend_q;
   logic                pinv_q;
   logic                pedge_q;
   logic [NCH-1:0]      term_q;
   logic [NCH-1:0]      inv_q;
   logic [NCH-1:0]      edge_q;
   logic [NCH-1:0]      disp_q;
   logic [STEP_W-1:0]   step_q [NCH];
   logic                mon_en_q;
   logic                trigger_programming_q;
   logic [NCH-1:0]      level;
   logic [NCH-1:0]      match;
   logic                hit;
   logic                wr_cmd;
   logic                wr_ctrl;
   logic [3:0]          code;
   logic [CH_W-1:0]     ch;
   logic                trigger_programming_mode;
   logic                sel_live;
   logic [31:0]         stat_rd;
   logic [31:0]         step_rd;

   function automatic logic [NCH-1:0] onehot(input logic [CH_W-1:0] c);
      return NCH'(1) << c;
   endfunction : onehot

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   apb_panel_if u_apb (
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .ctrl_rd ({31'h0000_0000, mon_en_q}),
      .stat_rd (stat_rd),
      .step_rd (step_rd),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .wr_cmd  (wr_cmd),
      .wr_ctrl (wr_ctrl)
   );

   // Command decode from the written word
   assign code      = pwdata[CMD_CODE_LSB +: CMD_CODE_W];
   assign ch        = pwdata[CMD_CH_LSB +: CH_W];
   assign trigger_programming_mode = (mode_q == trigger_programming);
   assign sel_live  = term_q[sel_q];

   // ----------------------------------------------------------------------
   // Programming mode
   // ----------------------------------------------------------------------
   // Program button flips between the two modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= channel_programming;
      end else if (wr_cmd && code == C_PROGRAM_MODE_SELECT) begin
         unique case (mode_q)
            channel_programming: mode_q <= trigger_programming; // R5
            trigger_programming: mode_q <= channel_programming; // R5
            default:             mode_q <= channel_programming;
         endcase
      end
   end

   // Channel selection is shared by both modes, as on the panel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= '0;
      end else if (wr_cmd && code == C_CHANNEL_PROGRAMMING) begin
         sel_q <= ch;
      end
   end

   // AND arms the next channel press to extend the product
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         and_pend_q <= 1'b0;
      end else if (wr_cmd && trigger_programming_mode) begin
         if (code == C_AND) begin
            and_pend_q <= 1'b1;
         end else if (code == C_CHANNEL_PROGRAMMING || code == C_CLEAR) begin
            and_pend_q <= 1'b0;
         end
      end
   end

   // Modifiers pressed while the selected channel has no live term wait for the next channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pinv_q  <= 1'b0;
         pedge_q <= 1'b0;
      end else if (wr_cmd && trigger_programming_mode) begin
         if (code == C_CHANNEL_PROGRAMMING || code == C_CLEAR) begin
            pinv_q  <= 1'b0;
            pedge_q <= 1'b0;
         end else if (code == C_NOT && !sel_live) begin
            pinv_q  <= ~pinv_q;
         end else if (code == C_EDGE && !sel_live) begin
            pedge_q <= ~pedge_q;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Trigger terms
   // ----------------------------------------------------------------------
   // A plain channel press starts a new single-term function; after AND it
   // joins the product. Clearing wipes polarity and edge too.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         term_q <= '0;
         inv_q  <= '0;
         edge_q <= '0;
      end else if (wr_cmd && trigger_programming_mode) begin
         unique case (code)
            C_CLEAR: begin
               term_q <= '0;                                 // R4
               inv_q  <= '0;                                 // R4
               edge_q <= '0;                                 // R4
            end
            C_CHANNEL_PROGRAMMING: begin
               if (and_pend_q) begin
                  term_q <= term_q | onehot(ch);             // R2
                  inv_q  <= (inv_q & ~onehot(ch)) | (pinv_q ? onehot(ch) : '0);
                  edge_q <= (edge_q & ~onehot(ch)) | (pedge_q ? onehot(ch) : '0);
               end else begin
                  term_q <= onehot(ch);                      // R6
                  inv_q  <= pinv_q ? onehot(ch) : '0;
                  edge_q <= pedge_q ? onehot(ch) : '0;
               end
            end
            C_NOT: begin
               if (sel_live) begin
                  inv_q <= inv_q ^ onehot(sel_q);            // R7 R8
               end
            end
            C_EDGE: begin
               if (sel_live) begin
                  edge_q <= edge_q ^ onehot(sel_q);          // R1
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Display and deflection
   // ----------------------------------------------------------------------
   // Display toggle in channel mode; trace, light and readout share it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_q <= onehot('0);
      end else if (wr_cmd && !trigger_programming_mode && code == C_DISPLAY) begin
         disp_q <= disp_q ^ onehot(sel_q);                   // R10
      end
   end

   // Deflection steps saturate at both ends rather than wrapping
   generate
      for (genvar i = 0; i < NCH; i++) begin : g_step
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               step_q[i] <= STEP_RST;
            end else if (wr_cmd && !trigger_programming_mode && sel_q == CH_W'(i)) begin
               if (code == C_VUP && step_q[i] != STEP_MAX) begin
                  step_q[i] <= step_q[i] + STEP_ONE;         // R11
               end else if (code == C_VDN && step_q[i] != STEP_MIN) begin
                  step_q[i] <= step_q[i] - STEP_ONE;
               end
            end
         end
         assign vdiv_step[i*STEP_W +: STEP_W] = step_q[i];
         assign step_rd[i*STEP_W +: STEP_W]   = step_q[i];
      end
   endgenerate
   assign step_rd[31:NCH*STEP_W] = '0;

   // Monitor trace enable, software controlled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_en_q <= CTRL_MON_RST;
      end else if (wr_ctrl) begin
         mon_en_q <= pwdata[CTRL_MON_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Trigger function
   // ----------------------------------------------------------------------
   // Levels bypass display state so hidden channels still trigger
   assign level = {input_four, input_three, input_two, input_one}; // R9

   generate
      for (genvar i = 0; i < NCH; i++) begin : g_term
         term_eval u_term (
            .pclk    (pclk),
            .presetn (presetn),
            .level   (level[i]),
            .en      (term_q[i]),
            .inv     (inv_q[i]),
            .edge_q  (edge_q[i]),
            .match   (match[i])
         );
      end
   endgenerate

   // Product of live terms; empty function never fires
   assign hit = (|term_q) & (&match);                        // R3 R13

   // Registered every cycle so the time base sees a clean level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_programming_q <= 1'b0;
      end else begin
         trigger_programming_q <= hit;                                      // R14
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign trigger_programming_out                = trigger_programming_q;
   assign trigger_monitor_trace   = trigger_programming_q & mon_en_q;       // R12
   assign program_mode_select_led = trigger_programming_mode;
   assign term_led_red            = term_q & ~inv_q;         // R6 R8
   assign term_led_green          = term_q & inv_q;          // R7
   assign term_led_flash          = term_q & edge_q;         // R1
   assign disp_on                 = disp_q;

   always_comb begin
      stat_rd                                 = 32'h0000_0000;
      stat_rd[ST_MODE_BIT]                    = trigger_programming_mode;
      stat_rd[ST_AND_BIT]                     = and_pend_q;
      stat_rd[ST_TERM_LSB +: NCH]             = term_q;
      stat_rd[ST_INV_LSB +: NCH]              = inv_q;
      stat_rd[ST_EDGE_LSB +: NCH]             = edge_q;
      stat_rd[ST_DISP_LSB +: NCH]             = disp_q;
      stat_rd[ST_SEL_LSB +: CH_W]             = sel_q;
      stat_rd[ST_TRIGGER_PROGRAMMING_BIT]                    = trigger_programming_q;
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_trigger_programming_cmd(logic [3:0] c);
      wr_cmd && trigger_programming_mode && code == c;
   endsequence

   sequence s_channel_programming_cmd(logic [3:0] c);
      wr_cmd && !trigger_programming_mode && code == c;
   endsequence

   a_edge_toggle: assert property (s_trigger_programming_cmd(C_EDGE) ##0 sel_live |=> // R1
      edge_q[$past(sel_q)] != $past(edge_q[sel_q]))
      else $error("edge press did not toggle selected term");

   a_and_extend: assert property (s_trigger_programming_cmd(C_CHANNEL_PROGRAMMING) ##0 and_pend_q |=> // R2
      term_q == ($past(term_q) | onehot($past(ch))))
      else $error("and-channel did not extend the product");

   a_no_terms: assert property (term_q == '0 |=> !trigger_programming_q) // R3
      else $error("trigger with no programmed term");

   a_clear_all: assert property (s_trigger_programming_cmd(C_CLEAR) |=> // R4
      term_q == '0 && term_led_red == '0 && term_led_green == '0 && term_led_flash == '0)
      else $error("clear left a term or indicator on");

   a_program_mode_select_toggle: assert property (wr_cmd && code == C_PROGRAM_MODE_SELECT |=> // R5
      mode_q != $past(mode_q) && program_mode_select_led == (mode_q == trigger_programming))
      else $error("program button did not toggle mode");

   a_channel_programming_single: assert property (s_trigger_programming_cmd(C_CHANNEL_PROGRAMMING) ##0 !and_pend_q && !pinv_q |=> // R6
      term_q == onehot($past(ch)) && term_led_red == onehot($past(ch)))
      else $error("channel press did not set a single red term");

   a_not_toggle: assert property (s_trigger_programming_cmd(C_NOT) ##0 sel_live |=> // R7
      term_led_green[$past(sel_q)] != $past(term_led_green[sel_q]))
      else $error("invert did not change term polarity");

   // Back-to-back writes on a zero-wait bus land two cycles apart
   a_not_twice: assert property (s_trigger_programming_cmd(C_NOT) ##0 sel_live ##2 // R8
      s_trigger_programming_cmd(C_NOT) ##0 sel_live |=> inv_q == $past(inv_q, 3))
      else $error("two inverts did not cancel");

   a_disp_toggle: assert property (s_channel_programming_cmd(C_DISPLAY) |=> // R10
      disp_on == ($past(disp_q) ^ onehot($past(sel_q))))
      else $error("display press did not toggle channel");

   a_vdiv_step: assert property (s_channel_programming_cmd(C_VUP) ##0 step_q[sel_q] != STEP_MAX |=> // R11
      step_q[$past(sel_q)] == $past(step_q[sel_q]) + STEP_ONE)
      else $error("deflection did not step once");

   // Tied to the function one cycle back, not to the output register
   a_monitor: assert property (##1 trigger_monitor_trace == (mon_en_q && $past(hit))) // R12
      else $error("monitor trace does not follow function");

   a_eval_cycle: assert property (##1 trigger_programming_q == $past(hit)) // R9 R13 R14
      else $error("trigger not evaluated every cycle");

endmodule : trigger_programming_panel

// [verilog/trigger_programming_panel_pkg.sv]
// Constants shared by the trigger-function panel: register map, field layout,
// command codes, reset values and the programming-mode state encoding.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit address bus.
package trigger_programming_panel_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam int          NCH        = 4;
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  A_CMD      = 8'h00;  // Write-only button command
   localparam logic [7:0]  A_CTRL     = 8'h04;  // Monitor trace enable
   localparam logic [7:0]  A_STAT     = 8'h08;  // Panel state
   localparam logic [7:0]  A_STEP     = 8'h0c;  // Deflection step per channel

   // ----------------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------------
   localparam int          CMD_CODE_LSB = 0;
   localparam int          CMD_CODE_W   = 4;
   localparam int          CMD_CH_LSB   = 4;
   localparam int          CH_W         = 2;
   localparam int          CTRL_MON_BIT = 0;
   localparam logic        CTRL_MON_RST = 1'b1;
   localparam int          ST_MODE_BIT  = 0;
   localparam int          ST_AND_BIT   = 1;
   localparam int          ST_TERM_LSB  = 4;
   localparam int          ST_INV_LSB   = 8;
   localparam int          ST_EDGE_LSB  = 12;
   localparam int          ST_DISP_LSB  = 16;
   localparam int          ST_SEL_LSB   = 20;
   localparam int          ST_TRIGGER_PROGRAMMING_BIT  = 24;
   localparam int          STEP_W       = 4;

   // ----------------------------------------------------------------------
   // Command codes written to A_CMD
   // ----------------------------------------------------------------------
   localparam logic [3:0]  C_PROGRAM_MODE_SELECT    = 4'h1;
   localparam logic [3:0]  C_CLEAR   = 4'h2;
   localparam logic [3:0]  C_NOT     = 4'h3;
   localparam logic [3:0]  C_EDGE    = 4'h4;
   localparam logic [3:0]  C_AND     = 4'h5;
   localparam logic [3:0]  C_CHANNEL_PROGRAMMING    = 4'h6;
   localparam logic [3:0]  C_DISPLAY = 4'h7;
   localparam logic [3:0]  C_VUP     = 4'h8;
   localparam logic [3:0]  C_VDN     = 4'h9;

   // ----------------------------------------------------------------------
   // Deflection steps: 0 = 5 V/div, rising index = more sensitive
   // 3 = 0.5 V/div, 4 = 0.2 V/div
   // ----------------------------------------------------------------------
   localparam logic [3:0]  STEP_RST  = 4'h3;
   localparam logic [3:0]  STEP_MAX  = 4'h9;
   localparam logic [3:0]  STEP_ONE  = 4'h1;
   localparam logic [3:0]  STEP_MIN  = 4'h0;

   typedef enum logic [1:0] {
      channel_programming = 2'b01,
      trigger_programming = 2'b10
   } program_mode_select_mode_t;

endpackage : trigger_programming_panel_pkg
